// file: shared/dav_pkg.sv
package dav_pkg;
   localparam int SAMPLE_W = 16;
   localparam int WORD_W = 16;
   localparam int RES_W = 32;
   localparam int ACC_W = 40;
   localparam int DEC_W = 16;
   localparam int ADDR_W = 7;
   localparam int GAIN_W = 25;
   localparam int GAIN_FRAC = 16;
   localparam int NUM_CH = 4;
   localparam int BUF_DEPTH = 2;

   // Channel order inside a sample word and inside the result array
   localparam int CH_ANG_Y = 0;
   localparam int CH_ANG_Z = 1;
   localparam int CH_VEL_X = 2;
   localparam int CH_VEL_Y = 3;
   localparam int NUM_ANG_CH = 2;

   // Trapezoid: sum of pairs times 1/(2*fs)
   localparam longint INT_SAMPLE_RATE_SPS = 2000;
   localparam longint TRAPEZ_DIV = 2;
   localparam longint VEL_RANGE_MPS = 400;
   localparam longint ANG_RANGE_DEG = 360;
   localparam longint ACCEL_UMPS2_PER_LSB = 12258;
   localparam longint GYRO_MDPS_PER_LSB = 100;
   localparam longint GAIN_NUM = 64'sd1 <<< (RES_W - 1 + GAIN_FRAC);
   localparam logic signed [GAIN_W-1:0] VEL_GAIN_DEF = GAIN_W'(
      GAIN_NUM * ACCEL_UMPS2_PER_LSB /
      (TRAPEZ_DIV * INT_SAMPLE_RATE_SPS * VEL_RANGE_MPS * 64'sd1000000));
   localparam logic signed [GAIN_W-1:0] ANG_GAIN_DEF = GAIN_W'(
      GAIN_NUM * GYRO_MDPS_PER_LSB /
      (TRAPEZ_DIV * INT_SAMPLE_RATE_SPS * ANG_RANGE_DEG * 64'sd1000));

   localparam logic signed [RES_W-1:0] RES_MAX = 32'sh7fffffff;
   localparam logic signed [RES_W-1:0] RES_MIN = 32'sh80000000;
   localparam logic [WORD_W-1:0] RD_UNMAPPED = 16'h0000;
   localparam logic [DEC_W-1:0] CNT_RESET = 16'h0000;

   // Byte addresses of the low byte of each word
   localparam logic [ADDR_W-1:0] ADDR_ANG_Y_LO = 7'h28;
   localparam logic [ADDR_W-1:0] ADDR_ANG_Y_HI = 7'h2a;
   localparam logic [ADDR_W-1:0] ADDR_ANG_Z_LO = 7'h2c;
   localparam logic [ADDR_W-1:0] ADDR_ANG_Z_HI = 7'h2e;
   localparam logic [ADDR_W-1:0] ADDR_VEL_X_LO = 7'h30;
   localparam logic [ADDR_W-1:0] ADDR_VEL_X_HI = 7'h32;
   localparam logic [ADDR_W-1:0] ADDR_VEL_Y_LO = 7'h34;
   localparam logic [ADDR_W-1:0] ADDR_VEL_Y_HI = 7'h36;

   typedef enum logic [1:0] {
      DAV_ST_ACC = 2'b01,
      DAV_ST_STORE = 2'b10
   } dav_state_t;
endpackage

// file: logic/dav_pair_buf.sv
`timescale 1ns/1ns
module dav_pair_buf #(
   parameter int W = 64,
   parameter int DEPTH = dav_pkg::BUF_DEPTH
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   import dav_pkg::*;
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);

   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
      $error("dav_pair_buf: DEPTH must be a power of two, at least 2");
   end

   logic [W-1:0] mem [DEPTH];
   logic [PW-1:0] wr_ptr_r, wr_ptr_nxt, rd_ptr_r, rd_ptr_nxt;
   logic [CW-1:0] cnt_r, cnt_nxt;
   logic in_ready_r, in_ready_nxt;
   logic push, pop;

   assign in_ready = in_ready_r;
   assign out_valid = (cnt_r != '0);
   assign out_data = mem[rd_ptr_r];

   always_comb begin
      push = in_valid && in_ready_r;
      pop = out_valid && out_ready;
      wr_ptr_nxt = push ? PW'(wr_ptr_r + 1'b1) : wr_ptr_r;
      rd_ptr_nxt = pop ? PW'(rd_ptr_r + 1'b1) : rd_ptr_r;
      cnt_nxt = cnt_r;
      if (push && !pop) begin
         cnt_nxt = CW'(cnt_r + 1'b1);
      end else if (pop && !push) begin
         cnt_nxt = CW'(cnt_r - 1'b1);
      end
      // Ready is registered so the source sees no path from the drain side
      in_ready_nxt = (cnt_nxt != CW'(DEPTH));
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         cnt_r <= '0;
         in_ready_r <= 1'b0;
      end else begin
         wr_ptr_r <= wr_ptr_nxt;
         rd_ptr_r <= rd_ptr_nxt;
         cnt_r <= cnt_nxt;
         in_ready_r <= in_ready_nxt;
      end
   end

   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_ptr_r] <= in_data;
      end
   end

   a_buf_no_overflow: assert property (@(posedge clk) disable iff (rst)
      cnt_r <= CW'(DEPTH))
      else $error("pair buffer holds more words than its depth");
   a_buf_full_stalls: assert property (@(posedge clk) disable iff (rst)
      (cnt_r == CW'(DEPTH)) |-> !in_ready_r)
      else $error("pair buffer offers ready while full");
endmodule

// file: logic/dav_top.sv
`timescale 1ns/1ns
// Overview of operation
// [RL1] Velocity change: sum of accel sample plus predecessor, times 1/(2fs).
// [RL2] Window is decimation setting plus one samples; one result per update.
// [RL3] Integration scaling assumes the internal 2000 samples per second rate.
// [RL4] Host may refine results using measured update rate at setting zero.
// [RL5] Each velocity result is two 16-bit words: one 32-bit two's complement.
// [RL6] Upper velocity word: two's complement, zero 0x0000, 400/2^15 m/s LSB.
// [RL7] Lower velocity word holds bits 15:0 of the 32-bit result.
// [RL8] X velocity lower word at 0x30/0x31, upper at 0x32/0x33, read-only.
// [RL9] Y velocity lower word at 0x34/0x35, upper at 0x36/0x37, read-only.
// [RL10] Upper angle word: two's complement, zero is 0x0000, range/2^15 LSB.
// [RL11] Lower angle word holds bits 15:0 of the 32-bit angle result.
// [RL12] Y angle upper word at 0x2A/0x2B, read-only.
// [RL13] Z angle lower word at 0x2C/0x2D, upper at 0x2E/0x2F, read-only.
// [RL14] Code 0x80000000, and 0x8000 upper, mean minus full range.
// [RL15] Angle change uses the same trapezoid on gyroscope rate samples.
// [RL16] All result words load together on each update, so halves match.
// [RL17] Writes to result words leave their contents unchanged.
module dav_top #(
   parameter logic signed [dav_pkg::GAIN_W-1:0] ANG_GAIN =
      dav_pkg::ANG_GAIN_DEF,
   parameter logic signed [dav_pkg::GAIN_W-1:0] VEL_GAIN =
      dav_pkg::VEL_GAIN_DEF
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic smp_valid,
   output logic smp_ready,
   input wire logic signed [dav_pkg::SAMPLE_W-1:0] gyro_y,
   input wire logic signed [dav_pkg::SAMPLE_W-1:0] gyro_z,
   input wire logic signed [dav_pkg::SAMPLE_W-1:0] accel_x,
   input wire logic signed [dav_pkg::SAMPLE_W-1:0] accel_y,
   input wire logic [dav_pkg::DEC_W-1:0] decimation_setting,
   input wire logic rd_en,
   input wire logic [dav_pkg::ADDR_W-1:0] rd_addr,
   input wire logic wr_en,
   output logic rd_valid,
   output logic [dav_pkg::WORD_W-1:0] rd_data,
   output logic sample_update_pin
);
   import dav_pkg::*;
   localparam int SW = NUM_CH * SAMPLE_W;
   localparam int PW = ACC_W + GAIN_W;

   if (ANG_GAIN <= 0 || VEL_GAIN <= 0) begin : g_bad_gain
      $error("dav_top: gains must be positive");
   end

   function automatic logic signed [RES_W-1:0] dav_scale(
      input logic signed [ACC_W-1:0] acc,
      input logic signed [GAIN_W-1:0] gain);
      logic signed [PW-1:0] prod;
      logic signed [PW-1:0] shifted;
      logic [PW-RES_W:0] top;
      prod = PW'(acc) * PW'(gain);
      shifted = prod >>> GAIN_FRAC;
      top = shifted[PW-1:RES_W-1];
      // Clamp rather than wrap; a wrapped delta would flip its sign
      if (&top || ~|top) begin
         dav_scale = shifted[RES_W-1:0];
      end else if (shifted[PW-1]) begin
         dav_scale = RES_MIN;
      end else begin
         dav_scale = RES_MAX;
      end
   endfunction

   logic buf_valid, take;
   logic [SW-1:0] buf_data;
   dav_state_t state_r, state_nxt;
   logic [DEC_W-1:0] cnt_r, cnt_nxt;
   logic signed [ACC_W-1:0] acc_r [NUM_CH];
   logic signed [ACC_W-1:0] acc_nxt [NUM_CH];
   logic signed [SAMPLE_W-1:0] prev_r [NUM_CH];
   logic signed [SAMPLE_W-1:0] prev_nxt [NUM_CH];
   logic signed [SAMPLE_W:0] pair [NUM_CH];
   logic signed [RES_W-1:0] res_r [NUM_CH];
   logic signed [RES_W-1:0] res_nxt [NUM_CH];
   logic upd_r, upd_nxt;
   logic rd_valid_r, rd_valid_nxt;
   logic [WORD_W-1:0] rd_data_r, rd_data_nxt;
   logic [DEC_W:0] takes_r;

   assign sample_update_pin = upd_r;
   assign rd_valid = rd_valid_r;
   assign rd_data = rd_data_r;

   // The integrator pauses for one cycle per update; the buffer absorbs it
   dav_pair_buf #(
      .W(SW),
      .DEPTH(BUF_DEPTH)
   ) u_buf (
      .clk(clk),
      .rst(rst),
      .in_valid(smp_valid),
      .in_ready(smp_ready),
      .in_data({accel_y, accel_x, gyro_z, gyro_y}),
      .out_valid(buf_valid),
      .out_ready(state_r == DAV_ST_ACC),
      .out_data(buf_data)
   );

   // Integration and result loading
   always_comb begin
      take = buf_valid && (state_r == DAV_ST_ACC);
      state_nxt = state_r;
      cnt_nxt = cnt_r;
      upd_nxt = 1'b0;
      for (int c = 0; c < NUM_CH; c++) begin
         pair[c] = (SAMPLE_W+1)'(signed'(buf_data[c*SAMPLE_W +: SAMPLE_W]))
            + (SAMPLE_W+1)'(prev_r[c]);
         acc_nxt[c] = acc_r[c];
         prev_nxt[c] = prev_r[c];
         res_nxt[c] = res_r[c];
      end
      case (state_r)
         DAV_ST_ACC: begin
            if (take) begin
               for (int c = 0; c < NUM_CH; c++) begin
                  // Predecessor carries across window edges
                  acc_nxt[c] = acc_r[c] + ACC_W'(pair[c]); // RL1 RL15
                  prev_nxt[c] = buf_data[c*SAMPLE_W +: SAMPLE_W];
               end
               if (cnt_r >= decimation_setting) begin
                  state_nxt = DAV_ST_STORE; // RL2
               end else begin
                  cnt_nxt = DEC_W'(cnt_r + 1'b1);
               end
            end
         end
         DAV_ST_STORE: begin
            for (int c = 0; c < NUM_CH; c++) begin
               // Gains fold in 1/(2*2000) and the output LSB weight
               res_nxt[c] = dav_scale(acc_r[c],
                  (c < NUM_ANG_CH) ? ANG_GAIN : VEL_GAIN); // RL3 RL14 RL16
               acc_nxt[c] = '0;
            end
            cnt_nxt = CNT_RESET;
            upd_nxt = 1'b1; // RL2
            state_nxt = DAV_ST_ACC;
         end
         default: begin
            state_nxt = DAV_ST_ACC;
            cnt_nxt = CNT_RESET;
         end
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_r <= DAV_ST_ACC;
         cnt_r <= CNT_RESET;
         upd_r <= 1'b0;
         for (int c = 0; c < NUM_CH; c++) begin
            acc_r[c] <= '0;
            prev_r[c] <= '0;
            res_r[c] <= '0;
         end
      end else begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
         upd_r <= upd_nxt;
         for (int c = 0; c < NUM_CH; c++) begin
            acc_r[c] <= acc_nxt[c];
            prev_r[c] <= prev_nxt[c];
            res_r[c] <= res_nxt[c];
         end
      end
   end

   // Read port; both byte addresses of a word return that word
   always_comb begin
      rd_valid_nxt = rd_en;
      rd_data_nxt = rd_data_r;
      if (rd_en) begin
         case (rd_addr[ADDR_W-1:1])
            ADDR_ANG_Y_LO[ADDR_W-1:1]:
               rd_data_nxt = res_r[CH_ANG_Y][WORD_W-1:0]; // RL11
            ADDR_ANG_Y_HI[ADDR_W-1:1]:
               rd_data_nxt = res_r[CH_ANG_Y][RES_W-1:WORD_W]; // RL12 RL10
            ADDR_ANG_Z_LO[ADDR_W-1:1]:
               rd_data_nxt = res_r[CH_ANG_Z][WORD_W-1:0]; // RL13 RL11
            ADDR_ANG_Z_HI[ADDR_W-1:1]:
               rd_data_nxt = res_r[CH_ANG_Z][RES_W-1:WORD_W]; // RL13 RL10
            ADDR_VEL_X_LO[ADDR_W-1:1]:
               rd_data_nxt = res_r[CH_VEL_X][WORD_W-1:0]; // RL8 RL7
            ADDR_VEL_X_HI[ADDR_W-1:1]:
               rd_data_nxt = res_r[CH_VEL_X][RES_W-1:WORD_W]; // RL8 RL6
            ADDR_VEL_Y_LO[ADDR_W-1:1]:
               rd_data_nxt = res_r[CH_VEL_Y][WORD_W-1:0]; // RL9 RL7
            ADDR_VEL_Y_HI[ADDR_W-1:1]:
               rd_data_nxt = res_r[CH_VEL_Y][RES_W-1:WORD_W]; // RL9 RL5
            default:
               rd_data_nxt = RD_UNMAPPED;
         endcase
      end
   end

   // No write path reaches the result words; wr_en is watched only
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rd_valid_r <= 1'b0;
         rd_data_r <= RD_UNMAPPED;
      end else begin
         rd_valid_r <= rd_valid_nxt;
         rd_data_r <= rd_data_nxt; // RL17
      end
   end

   // Helper for the window assertion only
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         takes_r <= '0;
      end else if (state_r == DAV_ST_STORE) begin
         takes_r <= '0;
      end else if (take) begin
         takes_r <= (DEC_W+1)'(takes_r + 1'b1);
      end
   end

   a_window_length: assert property (@(posedge clk) disable iff (rst) // RL2
      (state_r == DAV_ST_STORE && $stable(decimation_setting)) |->
      takes_r == (DEC_W+1)'({1'b0, decimation_setting} + 1'b1))
      else $error("window did not span setting plus one samples");

   a_update_pulse: assert property (@(posedge clk) disable iff (rst) // RL2
      (state_r == DAV_ST_STORE) |=> sample_update_pin ##1 !sample_update_pin)
      else $error("update pulse missing or longer than one cycle");

   a_trapezoid_sum: assert property (@(posedge clk) disable iff (rst) // RL1
      (take && state_r == DAV_ST_ACC) |=> acc_r[CH_VEL_X] ==
      $past(acc_r[CH_VEL_X]) + ACC_W'($past(pair[CH_VEL_X])))
      else $error("velocity accumulator missed sample plus predecessor");

   a_gyro_prev: assert property (@(posedge clk) disable iff (rst) // RL15
      take |=> prev_r[CH_ANG_Y] == $past(buf_data[SAMPLE_W-1:0]))
      else $error("angle predecessor not taken from last gyro sample");

   a_results_coherent: assert property ( // RL16
      @(posedge clk) disable iff (rst)
      ($past(state_r) != DAV_ST_STORE) |->
      ($stable(res_r[CH_VEL_X]) && $stable(res_r[CH_ANG_Z])))
      else $error("result words changed outside an update");

   a_write_ignored: assert property (@(posedge clk) disable iff (rst) // RL17
      (wr_en && state_r == DAV_ST_ACC) |=> $stable(res_r[CH_VEL_Y]))
      else $error("write altered a result word");

   a_vel_x_low: assert property (@(posedge clk) disable iff (rst) // RL8
      (rd_en && rd_addr == ADDR_VEL_X_LO) |=>
      (rd_valid && rd_data == $past(res_r[CH_VEL_X][WORD_W-1:0])))
      else $error("x velocity low word read wrong");

   a_vel_y_high: assert property (@(posedge clk) disable iff (rst) // RL9
      (rd_en && rd_addr == 7'h37) |=>
      rd_data == $past(res_r[CH_VEL_Y][RES_W-1:WORD_W]))
      else $error("y velocity high word read wrong");

   // Second word is compared with what it held when read; an update may
   // land on the very next edge
   a_ang_words: assert property (@(posedge clk) disable iff (rst) // RL12 RL13
      (rd_en && rd_addr == ADDR_ANG_Y_HI) ##1
      (rd_en && rd_addr == ADDR_ANG_Z_LO) |=>
      ($past(rd_data) == $past(res_r[CH_ANG_Y][RES_W-1:WORD_W], 2) &&
      rd_data == $past(res_r[CH_ANG_Z][WORD_W-1:0])))
      else $error("angle word read wrong");

   a_zero_encoding: assert property ( // RL10
      @(posedge clk) disable iff (rst)
      (state_r == DAV_ST_STORE && acc_r[CH_ANG_Y] == '0) |=>
      res_r[CH_ANG_Y] == '0)
      else $error("zero integral not encoded as zero");
endmodule

// file: sim/dav_host_model.sv
`timescale 1ns/1ns
module dav_host_model (
   input wire logic clk,
   output logic rd_en,
   output logic [dav_pkg::ADDR_W-1:0] rd_addr,
   output logic wr_en,
   input wire logic rd_valid,
   input wire logic [dav_pkg::WORD_W-1:0] rd_data
);
   import dav_pkg::*;

   initial begin
      rd_en = 1'b0;
      rd_addr = 7'h00;
      wr_en = 1'b0;
   end

   // Host-side refinement with a measured update rate at setting zero
   function automatic longint refine(input longint res, input longint hz);
      return res * INT_SAMPLE_RATE_SPS / hz;
   endfunction

   // Answer is sampled one cycle after the request, where it stands
   task automatic read_word(input logic [ADDR_W-1:0] a,
         output logic [WORD_W-1:0] d, output logic v);
      @(posedge clk);
      rd_en <= 1'b1;
      rd_addr <= a;
      @(posedge clk);
      rd_en <= 1'b0;
      // Released address must not keep looking valid
      rd_addr <= ~a;
      @(negedge clk);
      v = rd_valid;
      d = rd_data;
   endtask

   // Two reads on consecutive edges; the first answer stands for one cycle, the second until the next read
   task automatic read_two(input logic [ADDR_W-1:0] a0,
         input logic [ADDR_W-1:0] a1, output logic [WORD_W-1:0] d0,
         output logic [WORD_W-1:0] d1);
      @(posedge clk);
      rd_en <= 1'b1;
      rd_addr <= a0;
      @(posedge clk);
      rd_addr <= a1;
      @(negedge clk);
      d0 = rd_data;
      @(posedge clk);
      rd_en <= 1'b0;
      rd_addr <= ~a1;
      @(negedge clk);
      d1 = rd_data;
   endtask

   task automatic write_try(input logic [ADDR_W-1:0] a);
      @(posedge clk);
      wr_en <= 1'b1;
      rd_addr <= a;
      @(posedge clk);
      wr_en <= 1'b0;
   endtask
endmodule

// file: sim/tb.sv
`timescale 1ns/1ns
module tb;
   import dav_pkg::*;
   // Angle gain large enough to reach the clamp, velocity gain unity
   localparam logic signed [GAIN_W-1:0] AG = 25'sh0800000;
   localparam logic signed [GAIN_W-1:0] VG = 25'sh0010000;
   localparam logic [ADDR_W-1:0] LO_ADDR [NUM_CH] = '{ADDR_ANG_Y_LO,
      ADDR_ANG_Z_LO, ADDR_VEL_X_LO, ADDR_VEL_Y_LO};
   localparam logic [ADDR_W-1:0] HI_ADDR [NUM_CH] = '{ADDR_ANG_Y_HI,
      ADDR_ANG_Z_HI, ADDR_VEL_X_HI, ADDR_VEL_Y_HI};
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic smp_valid = 1'b0;
   logic signed [SAMPLE_W-1:0] smp [NUM_CH] = '{default: 16'sh0000};
   logic [DEC_W-1:0] dec = 16'h0000;
   logic smp_ready, rd_en, wr_en, rd_valid, sample_update_pin;
   logic [ADDR_W-1:0] rd_addr;
   logic [WORD_W-1:0] rd_data;
   int miscompares = 0;
   int tests_run = 0;
   int pulses = 0;
   logic rdy_s = 1'b0;
   logic ready_low_seen = 1'b0;
   longint prev [NUM_CH] = '{default: 0};
   longint acc [NUM_CH];
   logic [RES_W-1:0] exp_res [NUM_CH] = '{default: 32'h0};
   logic [WORD_W-1:0] pr0, pr1;

   always #10 clk = ~clk;

   // Registered outputs only move at rising edges, so the falling edge
   // shows what the next rising edge will see
   always @(negedge clk) begin
      rdy_s = smp_ready;
      if (smp_ready === 1'b0 && rst === 1'b0) ready_low_seen = 1'b1;
      if (sample_update_pin === 1'b1) pulses++;
   end

   dav_top #(.ANG_GAIN(AG), .VEL_GAIN(VG)) DUT (
      .clk(clk), .rst(rst), .smp_valid(smp_valid), .smp_ready(smp_ready),
      .gyro_y(smp[CH_ANG_Y]), .gyro_z(smp[CH_ANG_Z]),
      .accel_x(smp[CH_VEL_X]), .accel_y(smp[CH_VEL_Y]),
      .decimation_setting(dec), .rd_en(rd_en), .rd_addr(rd_addr),
      .wr_en(wr_en), .rd_valid(rd_valid), .rd_data(rd_data),
      .sample_update_pin(sample_update_pin));

   dav_host_model host (.clk(clk), .rd_en(rd_en), .rd_addr(rd_addr),
      .wr_en(wr_en), .rd_valid(rd_valid), .rd_data(rd_data));

   task automatic check(input string what, input logic [31:0] seen,
         input logic [31:0] expv);
      tests_run++;
      if (seen !== expv) begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", what, expv, seen);
      end
   endtask

   task automatic close_out();
      $display("checks %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   function automatic logic [31:0] scale(input longint s, input longint g);
      longint r;
      r = (s * g) >>> 16;
      if (r > 64'sh7fffffff) r = 64'sh7fffffff;
      if (r < -64'sh80000000) r = -64'sh80000000;
      return r[31:0];
   endfunction

   task automatic rd_chk(input logic [ADDR_W-1:0] a,
         input logic [WORD_W-1:0] e);
      logic [WORD_W-1:0] d;
      logic v;
      host.read_word(a, d, v);
      check("rd_valid", {31'h0, v}, 32'h1);
      check($sformatf("word %h", a), {16'h0, d}, {16'h0, e});
   endtask

   task automatic check_all();
      for (int c = 0; c < NUM_CH; c++) begin
         rd_chk(LO_ADDR[c], exp_res[c][15:0]);
         rd_chk(HI_ADDR[c], exp_res[c][31:16]);
      end
   endtask

   // Sends n samples back to back; sample k of a channel is base + k*step
   task automatic run(input logic [DEC_W-1:0] d, input int n,
         input int b0, input int b1, input int b2, input int b3,
         input int step);
      int base [NUM_CH];
      longint v;
      int w;
      int nup;
      base = '{b0, b1, b2, b3};
      nup = n / (int'(d) + 1);
      pulses = 0;
      @(posedge clk);
      dec <= d;
      for (int k = 0; k < n; k++) begin
         smp_valid <= 1'b1;
         // Results hold only the last window, so the model restarts too
         if (k % (int'(d) + 1) == 0) acc = '{default: 0};
         for (int c = 0; c < NUM_CH; c++) begin
            v = base[c] + k * step;
            smp[c] <= v[15:0];
            acc[c] += v + prev[c];
            prev[c] = v;
         end
         w = 0;
         do begin
            @(posedge clk);
            w++;
         end while (rdy_s !== 1'b1 && w < 50);
         if (w >= 50) check("smp_ready", 32'h0, 32'h1);
      end
      smp_valid <= 1'b0;
      for (int c = 0; c < NUM_CH; c++) smp[c] <= ~smp[c];
      for (int i = 0; i < 60 && pulses < nup; i++) @(negedge clk);
      repeat (4) @(negedge clk);
      // One update per window of setting plus one samples
      check("updates", pulses, nup);
      for (int c = 0; c < NUM_CH; c++) begin
         exp_res[c] = scale(acc[c], c < NUM_ANG_CH ? longint'(AG)
            : longint'(VG));
      end
   endtask

   initial begin
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      check_all();
      rd_chk(7'h3a, RD_UNMAPPED);
      rd_chk(7'h20, RD_UNMAPPED);
      run(16'h0003, 4, 100, -200, 3000, -7, 5);
      check_all();
      rd_chk(ADDR_VEL_X_HI | 7'h01, exp_res[CH_VEL_X][31:16]);
      rd_chk(ADDR_ANG_Z_LO | 7'h01, exp_res[CH_ANG_Z][15:0]);
      rd_chk(ADDR_VEL_Y_HI | 7'h01, exp_res[CH_VEL_Y][31:16]);
      host.read_two(ADDR_ANG_Y_HI, ADDR_ANG_Z_LO, pr0, pr1);
      check("pair hi", {16'h0, pr0},
         {16'h0, exp_res[CH_ANG_Y][31:16]});
      check("pair lo", {16'h0, pr1},
         {16'h0, exp_res[CH_ANG_Z][15:0]});
      for (int c = 0; c < NUM_CH; c++) begin
         host.write_try(LO_ADDR[c]);
         host.write_try(HI_ADDR[c]);
      end
      check_all();
      run(16'h0001, 2, -1000, -30000, -5, 20000, -3);
      check_all();
      // Full rate input outruns the integrator, so the buffer must refuse
      ready_low_seen = 1'b0;
      run(16'h0000, 8, 1, 2, 3, 4, 1000);
      check("ready_low", {31'h0, ready_low_seen}, 32'h1);
      check_all();
      run(16'd299, 300, -32768, 32767, -32768, 32767, 0);
      check_all();
      // Pairs of this window cancel, so the Y angle result must be zero
      run(16'h0001, 2, 10000, 0, 0, 0, 2768);
      check_all();
      close_out();
   end

   initial begin
      #(20 * 10000);
      miscompares++;
      close_out();
   end
endmodule
